// [verilog/timeout_reset_flag_top.v]
/*
  Watchdog timer with timed unlock, reset-cause flags and reference enable.
  Assumes the watchdog oscillator tick and the reset event inputs arrive from
  outside the clock domain; each passes two flip-flops before use. The
  oscillator tick is a slow square wave; one counted cycle per rising edge.
*/
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timeout_reset_flag_defines.vh"

module timeout_reset_flag_top #(
  parameter CNT_W = 22
) (
  // Clock, reset and clock enable.
  input wire clk,
  input wire nrst,
  input wire clk_en,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Watchdog oscillator and restart instruction.
  input wire wdt_osc,
  input wire restart_pulse,
  // Fuses and reset sources (asynchronous levels).
  input wire safety_level_fuse,
  input wire powerup_event,
  input wire pin_reset_event,
  input wire supply_drop_event,
  input wire test_port_reset_instruction,
  // Reference enable terms.
  input wire supply_monitor_en,
  input wire comparator_bandgap_select,
  input wire converter_en,
  // Outputs.
  output reg chip_reset_pulse,
  output reg vref_on
);

  // Two-stage synchronisers for the oscillator, fuse, reset events, comparator select and converter enable.
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  wire [7:0] async_in = {test_port_reset_instruction, supply_drop_event, pin_reset_event, powerup_event,
                         safety_level_fuse, converter_en, comparator_bandgap_select, wdt_osc};
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (clk_en) begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end
  wire osc_s = sync2_q[0];
  wire comparator_bandgap_select_s = sync2_q[1];
  wire adc_s = sync2_q[2];
  wire level2 = sync2_q[3]; // RQ4
  wire por_s = sync2_q[4];
  wire pin_s = sync2_q[5];
  wire sup_s = sync2_q[6];
  wire tp_s = sync2_q[7];

  // Timeout length for a period code.
  function [CNT_W-1:0] period_of;
    input [2:0] code;
    begin
      period_of = `TIMEOUT_RESET_FLAG_BASE_TIMEOUT << code; // RQ11
    end
  endfunction

  // Register state.
  reg osc_prev_q;
  reg on_q;
  reg [2:0] sel_q;
  reg unlock_q;
  reg [2:0] win_q;
  reg [CNT_W-1:0] cnt_q;
  reg [4:0] stat_q;
  reg [4:0] src_prev_q;

  // APB access decode; zero-wait answers.
  wire acc = psel && penable && pready;
  wire wr_ctrl = acc && pwrite && (paddr == `TIMEOUT_RESET_FLAG_ADDR_CTRL);
  wire wr_stat = acc && pwrite && (paddr == `TIMEOUT_RESET_FLAG_ADDR_STATUS);
  wire w_on = pwdata[`TIMEOUT_RESET_FLAG_BIT_ON];
  wire w_unl = pwdata[`TIMEOUT_RESET_FLAG_BIT_UNLOCK];
  wire on_eff = on_q || level2; // RQ7
  wire osc_tick = osc_s && !osc_prev_q; // RQ1
  wire timeout = on_eff && osc_tick && (cnt_q == period_of(sel_q) - 1'b1); // RQ3

  // Hardware reset events sample as rising edges of their levels.
  wire [4:0] src_now = {tp_s, 1'b0, sup_s, pin_s, por_s};
  wire [4:0] src_rise = src_now & ~src_prev_q;
  wire chip_rst = (|src_rise) || chip_reset_pulse;

  // Watchdog control: enable, period and unlock window.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      on_q <= 1'b0;
      sel_q <= `TIMEOUT_RESET_FLAG_CTRL_RST;
      unlock_q <= 1'b0;
      win_q <= 3'h0;
      osc_prev_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      chip_reset_pulse <= 1'b0;
    end else if (clk_en) begin
      osc_prev_q <= osc_s;
      chip_reset_pulse <= timeout; // RQ20
      if (unlock_q) begin
        if (win_q == `TIMEOUT_RESET_FLAG_UNLOCK_CYCLES - 3'h1) begin
          unlock_q <= 1'b0; // RQ9
          win_q <= 3'h0;
        end else begin
          win_q <= win_q + 3'h1;
        end
      end
      if (wr_ctrl) begin
        if (w_unl && w_on) begin
          unlock_q <= 1'b1;
          win_q <= 3'h0;
          on_q <= 1'b1;
        end else if (unlock_q && !w_unl) begin
          sel_q <= pwdata[`TIMEOUT_RESET_FLAG_SEL_HI:`TIMEOUT_RESET_FLAG_SEL_LO]; // RQ10
          on_q <= w_on; // RQ8
          unlock_q <= 1'b0;
        end else if (w_on) begin
          on_q <= 1'b1; // RQ5
        end
        // Otherwise a late disable or period write is dropped. RQ22
      end
      if (restart_pulse || !on_eff || chip_rst || timeout) begin
        cnt_q <= {CNT_W{1'b0}}; // RQ2
      end else if (osc_tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Reset-cause flags; a hardware set wins over a software clear.
  wire [4:0] set_v = {src_rise[4], chip_reset_pulse, src_rise[2:0]};
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= `TIMEOUT_RESET_FLAG_STAT_RST;
      src_prev_q <= 5'h00;
    end else if (clk_en) begin
      src_prev_q <= src_now;
      if (src_rise[`TIMEOUT_RESET_FLAG_BIT_POWERUP_RESET_FLAG]) begin
        stat_q <= `TIMEOUT_RESET_FLAG_STAT_RST; // RQ17
      end else begin
        // Writing one keeps a flag; writing zero clears it. RQ21
        stat_q <= (wr_stat ? (stat_q & pwdata[4:0]) : stat_q) | set_v; // RQ13 RQ14 RQ15 RQ16
      end
    end
  end

  // APB answer registers and reference enable.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      vref_on <= 1'b0;
    end else if (clk_en) begin
      vref_on <= supply_monitor_en || comparator_bandgap_select_s || adc_s; // RQ18
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        if (paddr == `TIMEOUT_RESET_FLAG_ADDR_CTRL) begin
          prdata <= {27'h0, unlock_q, on_eff, sel_q}; // RQ12
        end else if (paddr == `TIMEOUT_RESET_FLAG_ADDR_STATUS) begin
          prdata <= {27'h0, stat_q};
        end else begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [shared/timeout_reset_flag_defines.vh]
/*
  Constants for the watchdog and reset-cause block: register byte addresses,
  field positions, reset values and timing figures.
  Assumes a single 100 MHz system clock and an APB slave with 32-bit data.
*/
// Notes on behaviour
// [RQ1] Counter runs on separate roughly 1 MHz oscillator.
// [RQ2] Restart, disable and chip reset clear counter.
// [RQ3] Enabled counter reaching period issues chip reset.
// [RQ4] Fuse picks level one (off) or two (on).
// [RQ5] Level one: writing enable one needs no unlock.
// [RQ6] Software: unlock write, then config within four cycles.
// [RQ7] Level two: always enabled, reads one, no disable.
// [RQ8] Level two period change ignores written enable value.
// [RQ9] Unlock bit self-clears four clocks after set.
// [RQ10] Disable and period change only while unlocked.
// [RQ11] Period code n gives 16K shifted by n cycles.
// [RQ12] Control bits seven to five read zero.
// [RQ13] Test-port reset sets bit four; zero write clears.
// [RQ14] Watchdog reset sets bit three; zero write clears.
// [RQ15] Supply-drop reset sets bit two; zero write clears.
// [RQ16] Pin reset sets bit one; zero write clears.
// [RQ17] Power-up sets bit zero; only software clears.
// [RQ18] Reference on for monitor, comparator select, or converter.
// [RQ19] Software should read and clear flags early.
// [RQ20] Timeout reset pulse lasts one system clock.
// [RQ21] Writing one to a flag changes nothing.
// [RQ22] Late disable or period writes are ignored.
`ifndef TIMEOUT_RESET_FLAG_DEFINES_VH
`define TIMEOUT_RESET_FLAG_DEFINES_VH

// Register byte addresses.
`define TIMEOUT_RESET_FLAG_ADDR_STATUS 12'h000
`define TIMEOUT_RESET_FLAG_ADDR_CTRL 12'h004

// Reset-cause status bit positions.
`define TIMEOUT_RESET_FLAG_BIT_POWERUP_RESET_FLAG 0
`define TIMEOUT_RESET_FLAG_BIT_PINF 1
`define TIMEOUT_RESET_FLAG_BIT_SUPF 2
`define TIMEOUT_RESET_FLAG_BIT_TOF 3
`define TIMEOUT_RESET_FLAG_BIT_TPF 4

// Control register bit positions.
`define TIMEOUT_RESET_FLAG_BIT_ON 3
`define TIMEOUT_RESET_FLAG_BIT_UNLOCK 4
`define TIMEOUT_RESET_FLAG_SEL_HI 2
`define TIMEOUT_RESET_FLAG_SEL_LO 0

// Reset values.
`define TIMEOUT_RESET_FLAG_CTRL_RST 3'h0
`define TIMEOUT_RESET_FLAG_STAT_RST 5'h01

// Unlock window in system clocks and base timeout in oscillator cycles.
`define TIMEOUT_RESET_FLAG_UNLOCK_CYCLES 3'h4
`define TIMEOUT_RESET_FLAG_BASE_TIMEOUT 22'h004000

`endif

// [dv/timeout_reset_flag_sva.sv]
/* Port checker for timeout_reset_flag_top.
   Assumes binding to timeout_reset_flag_top with clk_en held high. */
`timescale 1ns/1ps
`default_nettype none
module timeout_reset_flag_sva (
  // Clock and bus.
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Watchdog and reference.
  input wire logic restart_pulse,
  input wire logic safety_level_fuse,
  input wire logic supply_monitor_en,
  input wire logic comparator_bandgap_select,
  input wire logic converter_en,
  input wire logic chip_reset_pulse,
  input wire logic vref_on
);
  // No user needs the reference while all three terms are low.
  wire logic no_use = !(supply_monitor_en || comparator_bandgap_select || converter_en);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  pulse_one_clk_a: assert property (chip_reset_pulse |=> !chip_reset_pulse)
    else $error("timeout pulse too long");
  restart_holds_a: assert property (restart_pulse |-> ##2 !chip_reset_pulse [*8])
    else $error("timeout right after restart");
  vref_rise_a: assert property (supply_monitor_en |=> vref_on)
    else $error("reference off while monitor on");
  vref_fall_a: assert property (no_use [*4] |=> !vref_on)
    else $error("reference on with no user");
  ctrl_rsvd_a: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:5] == 27'h0)
    else $error("control upper bits not zero");
  lvl2_on_a: assert property (safety_level_fuse [*4] ##0 (pready && !pwrite && paddr == 12'h004) |-> prdata[3])
    else $error("enable reads zero at level two");
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
/* Bench for timeout_reset_flag_top over APB.
   Assumes timeout_reset_flag_defines.vh on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "timeout_reset_flag_defines.vh"
module tb_top;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, run = 0, rp = 0, fuse = 0, pwr = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, crp, vref;
  logic [2:0] ev = 0, vr = 0;
  logic [31:0] fl [3] = '{32'h02, 32'h06, 32'h16};
  int n_mismatch = 0, n_compared = 0, cyc = 0, t0;
  localparam logic [11:0] st = `TIMEOUT_RESET_FLAG_ADDR_STATUS, ct = `TIMEOUT_RESET_FLAG_ADDR_CTRL;
  timeout_reset_flag_top dut (.clk(clk), .nrst(nrst), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_osc(osc),
    .restart_pulse(rp), .safety_level_fuse(fuse), .powerup_event(pwr), .pin_reset_event(ev[0]),
    .supply_drop_event(ev[1]), .test_port_reset_instruction(ev[2]), .supply_monitor_en(vr[0]),
    .comparator_bandgap_select(vr[1]), .converter_en(vr[2]), .chip_reset_pulse(crp), .vref_on(vref));
  always #5 clk = ~clk;
  // Oscillator at a quarter of the clock so the shortest period fits the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (run && cyc[0]) osc <= ~osc;
    if (cyc == 80000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer, then an idle cycle so no signal is driven twice at one edge.
  // Pready is looked at mid-cycle, where it has settled for the coming edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    psel <= 1;
    @(posedge clk);
    penable <= 1;
    @(negedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
      @(negedge clk);
    end
    if (n >= 20) n_mismatch++;
    rdat = prdata;
    @(posedge clk);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(st, 32'h01);
    rd(ct, 32'h00);
    xfer(1'b1, st, 32'h1f);
    rd(st, 32'h01);
    xfer(1'b1, st, 32'h00);
    rd(st, 32'h00);
    for (int i = 0; i < 3; i++) begin
      ev <= 3'h1 << i;
      repeat (5) @(posedge clk);
      rd(st, fl[i]);
    end
    xfer(1'b1, st, 32'h06);
    rd(st, 32'h06);
    pwr <= 1;
    repeat (5) @(posedge clk);
    rd(st, 32'h01);
    xfer(1'b1, ct, 32'h18);
    xfer(1'b1, ct, 32'h05);
    rd(ct, 32'h05);
    xfer(1'b1, ct, 32'h08);
    rd(ct, 32'h0d);
    xfer(1'b1, ct, 32'h00);
    rd(ct, 32'h0d);
    xfer(1'b1, ct, 32'h1d);
    rd(ct, 32'h1d);
    rd(ct, 32'h0d);
    xfer(1'b1, ct, 32'h00);
    rd(ct, 32'h0d);
    xfer(1'b1, ct, 32'h1d);
    xfer(1'b1, ct, 32'h08);
    rd(ct, 32'h08);
    rp <= 1;
    @(posedge clk);
    rp <= 0;
    run <= 1;
    t0 = cyc;
    while (crp !== 1'b1) @(posedge clk);
    chk({31'h0, cyc - t0 > 65520 && cyc - t0 < 65560}, 32'h1);
    run <= 0;
    @(posedge clk);
    rd(st, 32'h09);
    xfer(1'b1, ct, 32'h18);
    xfer(1'b1, ct, 32'h00);
    rd(ct, 32'h00);
    fuse <= 1;
    repeat (5) @(posedge clk);
    xfer(1'b1, ct, 32'h00);
    rd(ct, 32'h08);
    xfer(1'b1, ct, 32'h18);
    xfer(1'b1, ct, 32'h03);
    rd(ct, 32'h0b);
    rd(12'h008, 32'h0);
    for (int i = 0; i < 3; i++) begin
      vr <= 3'h1 << i;
      repeat (4) @(posedge clk);
      chk({31'h0, vref}, 32'h1);
      vr <= 0;
      repeat (5) @(posedge clk);
      chk({31'h0, vref}, 32'h0);
    end
    summarize();
  end
endmodule
bind timeout_reset_flag_top timeout_reset_flag_sva chk (.*);
`default_nettype wire
